// ==== verilog/key_select_regs.vh ====
// Constants for the transport key slot selection block.
`ifndef KEY_SELECT_REGS_VH
`define KEY_SELECT_REGS_VH
`define KS_TRANSPORT_BIT 15
`define KS_SLOT_MSB 3
`define KS_OP_NONCE 8'h16
`define KS_OP_DIGEST 8'h15
`define KS_OP_WRITE 8'h12
`define KS_OP_LOCK 8'h17
`define KS_ERR_NONE 8'h00
`define KS_ERR_PARSE 8'h03
`define KS_ERR_EXEC 8'h0F
`define KS_STEP_IDLE 3'h0
`define KS_STEP_NONCE 3'h1
`define KS_STEP_TRANSPORT 3'h2
`define KS_STEP_CFG0 3'h3
`define KS_STEP_CFG1 3'h4
`endif

// ==== verilog/transport_key_decode.v ====
// Combinational decode of a key selector into key source and slot number.
`timescale 1ns/1ps
`default_nettype none
`include "key_select_regs.vh"
module transport_key_decode (
  input wire [15:0] key_selector, // Selector as received
  input wire is_digest, // Command is digest generation
  output wire use_transport, // Key comes from the hidden array
  output wire [3:0] slot_num, // Data-zone slot or transport index
  output wire illegal // Transport key asked by another command
);
  wire high_sel;
  assign high_sel = key_selector[`KS_TRANSPORT_BIT];
  assign use_transport = high_sel & is_digest;
  assign slot_num = key_selector[`KS_SLOT_MSB:0];
  assign illegal = high_sel & ~is_digest;
endmodule // transport_key_decode
`default_nettype wire

// ==== verilog/transport_key_slot_select.v ====
// Key source selection and personalization sequence tracking for digest commands.
// Behaviour
// - A key selector of 0x8000 or more picks a key from the hidden transport array.
// - Only the digest-generation command may use a transport key.
// - A selector below 0x8000 always picks an EEPROM data-zone slot, for any command.
// - The data-zone slot number is the lowest four selector bits only.
// - The whole 16-bit selector as received goes into the hash message.
// - The closing encrypted write targets the same slot and replaces its stored value.
// - With a transport key the scratch digest register must hold an internal random nonce.
`timescale 1ns/1ps
`default_nettype none
`include "key_select_regs.vh"
module transport_key_slot_select (
  input wire clk, // 10 MHz clock
  input wire reset, // Asynchronous reset, active high
  input wire cmd_valid, // One-cycle command strobe from the command engine
  input wire [7:0] cmd_opcode, // Command opcode
  input wire [15:0] key_selector, // Key selector field
  input wire [3:0] write_slot, // Target slot of an encrypted write
  input wire nonce_random, // Scratch digest register holds an RNG nonce
  output reg done, // One-cycle answer pulse
  output reg [7:0] status, // Answer status code
  output reg key_from_transport, // Key source is the hidden array
  output reg [3:0] key_slot, // Selected slot or transport index
  output reg key_enable, // Key fetch allowed for this command
  output reg [15:0] hash_selector, // Selector placed in the hash message
  output reg pers_key_written, // Personalization key slot was replaced
  output reg [3:0] pers_slot // Slot holding the personalization key
);
  localparam S_IDLE = 5'b00001;
  localparam S_NONCE = 5'b00010;
  localparam S_TRANS = 5'b00100;
  localparam S_CFG0 = 5'b01000;
  localparam S_CFG1 = 5'b10000;

  wire is_digest;
  wire is_nonce;
  wire is_write;
  wire use_tr;
  wire illegal;
  wire rng_missing;
  wire [3:0] slot_n;
  reg [4:0] seq_q;
  reg [4:0] seq_d;
  reg err_d;
  reg done_d;
  reg [7:0] status_d;
  reg key_from_transport_d;
  reg [3:0] key_slot_d;
  reg key_enable_d;
  reg [15:0] hash_selector_d;
  reg pers_key_written_d;
  reg [3:0] pers_slot_d;

  assign is_digest = (cmd_opcode == `KS_OP_DIGEST);
  assign is_nonce = (cmd_opcode == `KS_OP_NONCE);
  assign is_write = (cmd_opcode == `KS_OP_WRITE);

  transport_key_decode u_dec (
    .key_selector(key_selector),
    .is_digest(is_digest),
    .use_transport(use_tr),
    .slot_num(slot_n),
    .illegal(illegal)
  );

  // Transport digest without an internal nonce is refused; a pass-through
  // nonce would let the host replay the secret transport key.
  assign rng_missing = use_tr & ~nonce_random;

  always @* begin
    err_d = illegal | rng_missing;
  end

  // The sequence tracker only watches; it never blocks a command. A command
  // that breaks the expected order drops it back to idle, so a restarting nonce sent between
  // the transport digest and the closing write is lost and must be sent again.
  always @* begin
    seq_d = seq_q;
    if (cmd_valid) begin
      case (seq_q)
        S_IDLE: begin
          if (is_nonce && nonce_random) begin
            seq_d = S_NONCE;
          end
        end
        S_NONCE: begin
          if (use_tr && !err_d) begin
            seq_d = S_TRANS;
          end else if (!is_nonce || !nonce_random) begin
            seq_d = S_IDLE;
          end
        end
        S_TRANS: begin
          if (is_digest && !use_tr && !err_d) begin
            seq_d = S_CFG0;
          end else begin
            seq_d = S_IDLE;
          end
        end
        S_CFG0: begin
          if (is_digest && !use_tr && !err_d) begin
            seq_d = S_CFG1;
          end else begin
            seq_d = S_IDLE;
          end
        end
        S_CFG1: begin
          seq_d = S_IDLE;
        end
        default: begin
          seq_d = S_IDLE;
        end
      endcase
    end
  end

  // Answer fields other than the done pulse move only on a command strobe and hold until the next.
  always @* begin
    done_d = cmd_valid;
    status_d = status;
    key_from_transport_d = key_from_transport;
    key_slot_d = key_slot;
    key_enable_d = key_enable;
    hash_selector_d = hash_selector;
    pers_key_written_d = pers_key_written;
    pers_slot_d = pers_slot;
    if (cmd_valid) begin
      if (err_d) begin
        status_d = `KS_ERR_EXEC;
      end else begin
        status_d = `KS_ERR_NONE;
      end
      key_from_transport_d = use_tr & ~err_d;
      key_slot_d = slot_n;
      key_enable_d = ~err_d;
      hash_selector_d = key_selector;
      // The write that closes the sequence lands in the slot it encrypted for.
      if (seq_q == S_CFG1 && is_write) begin
        pers_key_written_d = 1'b1;
        pers_slot_d = write_slot;
      end
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      seq_q <= S_IDLE;
    end else begin
      seq_q <= seq_d;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      done <= 1'b0;
    end else begin
      done <= done_d;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      status <= `KS_ERR_NONE;
    end else begin
      status <= status_d;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      key_from_transport <= 1'b0;
    end else begin
      key_from_transport <= key_from_transport_d;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      key_slot <= 4'h0;
    end else begin
      key_slot <= key_slot_d;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      key_enable <= 1'b0;
    end else begin
      key_enable <= key_enable_d;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      hash_selector <= 16'h0000;
    end else begin
      hash_selector <= hash_selector_d;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      pers_key_written <= 1'b0;
    end else begin
      pers_key_written <= pers_key_written_d;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      pers_slot <= 4'h0;
    end else begin
      pers_slot <= pers_slot_d;
    end
  end
endmodule // transport_key_slot_select
`default_nettype wire

// ==== tb/ks_host.sv ====
// Host model that issues one command for one cycle, then drops the strobe and inverts the selector.
`timescale 1ns/1ps
`default_nettype none
module ks_host(input wire clk, output reg cmd_valid, output reg [7:0] cmd_opcode,
  output reg [15:0] key_selector, output reg [3:0] write_slot, output reg nonce_random);
  initial {cmd_valid, cmd_opcode, key_selector, write_slot, nonce_random} = 0;
  task send(input [7:0] op, input [15:0] sel, input rn);
    @(posedge clk);
    {cmd_valid, cmd_opcode, key_selector, write_slot, nonce_random} <= {1'b1, op, sel, sel[3:0], rn};
    @(posedge clk);
    cmd_valid <= 0;
    key_selector <= ~sel;
  endtask
endmodule // ks_host
`default_nettype wire

// ==== tb/ks_monitor.sv ====
// Checker of key selection answers.
`timescale 1ns/1ps
`default_nettype none
module ks_monitor(input wire clk, input wire reset, input wire cmd_valid,
  input wire [7:0] cmd_opcode, input wire [15:0] key_selector, input wire nonce_random,
  input wire done, input wire [7:0] status, input wire key_from_transport,
  input wire [3:0] key_slot, input wire key_enable, input wire [15:0] hash_selector);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire hi = cmd_valid && key_selector[15];
  wire dig = cmd_opcode == 8'h15;
  a_done_once: assert property (cmd_valid |=> done) else $error("no done");
  a_done_lone: assert property (!cmd_valid |=> !done) else $error("stray done");
  a_trans_pick: assert property (hi && dig && nonce_random |=> key_from_transport && key_enable)
    else $error("no transport key");
  a_other_refused: assert property (hi && !dig |=> status == 8'h0F && !key_from_transport)
    else $error("transport key misused");
  a_low_eeprom: assert property (cmd_valid && !key_selector[15] |=> !key_from_transport)
    else $error("low selector not eeprom");
  a_slot_bits: assert property (cmd_valid |=> key_slot == $past(key_selector[3:0]))
    else $error("slot bits wrong");
  a_hash_whole: assert property (cmd_valid |=> hash_selector == $past(key_selector))
    else $error("hash selector wrong");
  a_rng_needed: assert property (hi && !nonce_random |=> !key_enable && status == 8'h0F)
    else $error("transport without random nonce");
  cover property (hi && dig && nonce_random);
  cover property (hi && !dig);
  cover property (done && key_enable);
endmodule // ks_monitor
bind transport_key_slot_select ks_monitor mon(.*);
`default_nettype wire

// ==== tb/transport_key_slot_select_tb.sv ====
// Self-checking testbench for key selection.
`timescale 1ns/1ps
`default_nettype none
module transport_key_slot_select_tb;
  reg clk = 0, reset = 1, rn, bad;
  wire cmd_valid, nonce_random, done, key_from_transport, key_enable, pers_key_written;
  wire [7:0] cmd_opcode, status;
  wire [15:0] key_selector, hash_selector;
  wire [3:0] write_slot, key_slot, pers_slot;
  integer n_errors = 0, samples_checked = 0, i;
  reg [7:0] op;
  reg [15:0] sel;
  transport_key_slot_select uut(.clk(clk), .reset(reset), .cmd_valid(cmd_valid),
    .cmd_opcode(cmd_opcode), .key_selector(key_selector), .write_slot(write_slot),
    .nonce_random(nonce_random), .done(done), .status(status),
    .key_from_transport(key_from_transport), .key_slot(key_slot), .key_enable(key_enable),
    .hash_selector(hash_selector), .pers_key_written(pers_key_written), .pers_slot(pers_slot));
  ks_host host(.clk(clk), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
    .key_selector(key_selector), .write_slot(write_slot), .nonce_random(nonce_random));
  function automatic exp_bad(input [7:0] o, input [15:0] s, input r);
    exp_bad = s[15] && (o != 8'h15 || !r);
  endfunction
  initial forever #50 clk = ~clk;
  task chk(input string nm, input [15:0] seen, input [15:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task run;
    host.send(op, sel, rn);
    #1;
    bad = exp_bad(op, sel, rn);
    chk("done", done, 1);
    chk("status", status, bad ? 8'h0F : 8'h00);
    chk("enable", key_enable, !bad);
    chk("source", key_from_transport, sel[15] && !bad);
    chk("slot", key_slot, sel[3:0]);
    chk("hash", hash_selector, sel);
  endtask
  task test_done;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    n_errors = n_errors + 1;
    test_done;
  end
  initial begin
    i = $urandom(32'h261A);
    repeat (6) @(posedge clk);
    reset <= 0;
    rn = 1;
    for (i = 0; i < 5; i = i + 1) begin
      op = i == 4 ? 8'h12 : (i == 0 ? 8'h16 : 8'h15);
      sel = i == 1 ? 16'h8005 : (i == 4 ? 16'h0005 : (i == 3 ? 16'h0001 : 16'h0000));
      run;
    end
    chk("pers", {pers_key_written, pers_slot}, 16'h0015);
    for (i = 0; i < 60; i = i + 1) begin
      op = 32'h16151217 >> (8 * (i % 4));
      sel = i < 8 ? (i < 4 ? 16'h8000 : 16'h7FFF) : $urandom;
      rn = i < 8 ? 1'b1 : $urandom;
      run;
    end
    chk("pers_hold", pers_key_written, 1);
    test_done;
  end
endmodule // transport_key_slot_select_tb
`default_nettype wire
